// >>> logic/serial_port_status.sv
// status flag register of the synchronous serial port
// assumes classic wishbone on clk_i and a free-running link clock
//
// The implementer's own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_status_defs.svh"

module serial_port_status
   import serial_port_status_pkg::*;
(
   // system clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // link sampling clock
   input  wire logic        lclk_i,
   // wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   // bus pins
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   // steering toward the shifter and pad logic
   output logic             tx_on_idle_edge_o,
   output logic             smbus_thresh_o,
   output logic             port_enable_o
);

   link_tg_t   tg_link;
   link_byte_t byte_link;

   bus_watch u_watch (
      .lclk_i (lclk_i),
      .rst_i  (rst_i),
      .scl_i  (scl_i),
      .sda_i  (sda_i),
      .tg_o   (tg_link),
      .byte_o (byte_link)
   );

   // toggle crossing: two stages, then a third for the edge
   logic [3:0] tg_s1;
   logic [3:0] tg_s2;
   logic [3:0] tg_s3;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tg_s1 <= 4'h0;
         tg_s2 <= 4'h0;
         tg_s3 <= 4'h0;
      end else begin
         tg_s1 <= tg_link;
         tg_s2 <= tg_s1;
         tg_s3 <= tg_s2;
      end
   end

   wire [3:0] tg_evt = tg_s2 ^ tg_s3;

   // registers
   logic       smp_r;
   logic       cke_r;
   logic       da_r;
   logic       stop_r;
   logic       start_r;
   logic       rw_r;
   logic       rw_valid_r;
   logic       en_r;
   port_mode_t mode_r;
   logic [6:0] own_addr_r;
   logic       ack_r;
   logic [31:0] rdat_r;
   logic       tx_edge_r;
   logic       smbus_r;

   function automatic logic hit(input logic [7:0] a,
                                input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   wire req      = cyc_i && stb_i && !ack_r;
   wire sel_stat = hit(adr_i, `SPS_STATUS_OFS);
   wire sel_ctrl = hit(adr_i, `SPS_CTRL_OFS);
   wire wr_stat  = req && we_i && sel_stat && sel_i[0];
   wire wr_ctrl0 = req && we_i && sel_ctrl && sel_i[0];
   wire wr_ctrl1 = req && we_i && sel_ctrl && sel_i[1];
   wire rd_req   = req && !we_i;

   wire i2c_on   = en_r && (mode_r == MODE_I2C);

   // events reach the flags only while the port runs in i2c mode
   wire ev_start = tg_evt[3] && i2c_on;
   wire ev_stop  = tg_evt[2] && i2c_on;
   wire ev_byte  = tg_evt[1] && i2c_on;
   wire ev_nack  = tg_evt[0] && i2c_on;

   // byte word is stable here: it changed before its toggle crossed
   wire        byte_addr = byte_link.is_addr;
   wire [7:0]  byte_val  = byte_link.value;
   wire        addr_hit  = ev_byte && byte_addr &&
                           (byte_val[7:1] == own_addr_r);

   wire [7:0] status_rd = {smp_r, cke_r, da_r, stop_r,
                           start_r, rw_r, 1'b0, 1'b0};
   wire [31:0] ctrl_rd  = {17'h00000, own_addr_r, 6'h00,
                           mode_r, en_r};
   wire [31:0] rd_mux   = sel_stat ? {24'h000000, status_rd} :
                          sel_ctrl ? ctrl_rd : 32'h00000000;

   // start and stop flags: latest condition only
   wire start_nxt = !en_r    ? 1'b0 :
                    ev_start ? 1'b1 :
                    ev_stop  ? 1'b0 :
                    start_r;
   // start is put first here too, so a start and a stop landing in
   // one cycle can never leave both flags set
   wire stop_nxt  = !en_r    ? 1'b0 :
                    ev_start ? 1'b0 :
                    ev_stop  ? 1'b1 :
                    stop_r;

   // a byte that the watcher saw last decides data or address
   wire da_nxt = ev_byte ? !byte_addr : da_r;

   // direction is held after a match; the valid mark ends at
   // start, stop or nack; only the checks see it, the status read never does
   wire rw_nxt       = addr_hit ? byte_val[0] : rw_r;
   wire rw_valid_nxt = addr_hit ? 1'b1 :
                       (ev_start || ev_stop || ev_nack) ? 1'b0 :
                       rw_valid_r;

   // edge select means two things, split by mode
   wire tx_edge_nxt = (mode_r == MODE_SPI) && cke_r;
   wire smbus_nxt   = i2c_on && cke_r;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         smp_r  <= 1'b0;
         cke_r  <= 1'b0;
      end else if (wr_stat) begin
         smp_r  <= dat_i[`SPS_SMP_BIT];
         cke_r  <= dat_i[`SPS_CKE_BIT];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         en_r   <= 1'b0;
         mode_r <= MODE_SPI;
      end else if (wr_ctrl0) begin
         en_r   <= dat_i[`SPS_EN_BIT];
         mode_r <= port_mode_t'(dat_i[`SPS_MODE_BIT]);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         own_addr_r <= `SPS_OWN_ADDR_RST;
      end else if (wr_ctrl1) begin
         own_addr_r <= dat_i[`SPS_ADDR_MSB:`SPS_ADDR_LSB];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         start_r    <= 1'b0;
         stop_r     <= 1'b0;
         da_r       <= 1'b0;
         rw_r       <= 1'b0;
         rw_valid_r <= 1'b0;
      end else begin
         start_r    <= start_nxt;
         stop_r     <= stop_nxt;
         da_r       <= da_nxt;
         rw_r       <= rw_nxt;
         rw_valid_r <= rw_valid_nxt;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r     <= 1'b0;
         rdat_r    <= 32'h00000000;
         tx_edge_r <= 1'b0;
         smbus_r   <= 1'b0;
      end else begin
         ack_r     <= req;
         rdat_r    <= rd_req ? rd_mux : 32'h00000000;
         tx_edge_r <= tx_edge_nxt;
         smbus_r   <= smbus_nxt;
      end
   end

   assign dat_o             = rdat_r;
   assign ack_o             = ack_r;
   assign tx_on_idle_edge_o = tx_edge_r;
   assign smbus_thresh_o    = smbus_r;
   assign port_enable_o     = en_r;

   // checks on the flag and steering logic

   sequence s_start_seen;
      ev_start ##1 (start_r && !stop_r);
   endsequence

   sequence s_stop_seen;
      ev_stop ##1 (stop_r && !start_r);
   endsequence

   property p_start_flag;
      @(posedge clk_i) disable iff (rst_i)
      (ev_start && en_r) |-> s_start_seen;
   endproperty
   a_start_flag: assert property (p_start_flag)
      else $error("start flag not set by start");

   property p_stop_flag;
      @(posedge clk_i) disable iff (rst_i)
      (ev_stop && en_r && !ev_start) |-> s_stop_seen;
   endproperty
   a_stop_flag: assert property (p_stop_flag)
      else $error("stop flag not set by stop");

   property p_flags_hold;
      @(posedge clk_i) disable iff (rst_i)
      (en_r && !tg_evt[3] && !tg_evt[2]) |=>
         $stable(start_r) && $stable(stop_r);
   endproperty
   a_flags_hold: assert property (p_flags_hold)
      else $error("flag moved without a bus condition");

   property p_disable_clear;
      @(posedge clk_i) disable iff (rst_i)
      (wr_ctrl0 && !dat_i[`SPS_EN_BIT]) |=> ##1
         (!start_r && !stop_r);
   endproperty
   a_disable_clear: assert property (p_disable_clear)
      else $error("flags survive port disable");

   property p_flags_exclusive;
      @(posedge clk_i) disable iff (rst_i)
      !(start_r && stop_r);
   endproperty
   a_flags_exclusive: assert property (p_flags_exclusive)
      else $error("start and stop flags both set");

   property p_da_track;
      @(posedge clk_i) disable iff (rst_i)
      ev_byte |=> (da_r == !$past(byte_addr));
   endproperty
   a_da_track: assert property (p_da_track)
      else $error("data/address bit wrong after byte");

   property p_rw_capture;
      @(posedge clk_i) disable iff (rst_i)
      addr_hit |=> (rw_r == $past(byte_val[0])) && rw_valid_r;
   endproperty
   a_rw_capture: assert property (p_rw_capture)
      else $error("direction not captured on address match");

   property p_rw_window;
      @(posedge clk_i) disable iff (rst_i)
      ((ev_start || ev_stop || ev_nack) && !addr_hit) |=>
         !rw_valid_r;
   endproperty
   a_rw_window: assert property (p_rw_window)
      else $error("direction still valid after end event");

   property p_spi_edge;
      @(posedge clk_i) disable iff (rst_i)
      (wr_stat && mode_r == MODE_SPI && !wr_ctrl0) |=> ##1
         (tx_on_idle_edge_o == $past(dat_i[`SPS_CKE_BIT], 2));
   endproperty
   a_spi_edge: assert property (p_spi_edge)
      else $error("spi transmit edge not following select");

   property p_smbus;
      @(posedge clk_i) disable iff (rst_i)
      (mode_r == MODE_SPI) |=> !smbus_thresh_o;
   endproperty
   a_smbus: assert property (p_smbus)
      else $error("smbus thresholds on outside i2c mode");

   property p_smbus_on;
      @(posedge clk_i) disable iff (rst_i)
      (i2c_on && cke_r) [*2] |-> smbus_thresh_o;
   endproperty
   a_smbus_on: assert property (p_smbus_on)
      else $error("smbus thresholds not enabled");

   property p_ack_pulse;
      @(posedge clk_i) disable iff (rst_i)
      ack_o |=> !ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("ack held longer than one cycle");

endmodule

`default_nettype wire

// >>> logic/serial_port_status_defs.svh
// constants of the serial port status flag block
// assumes a 32-bit classic wishbone slave, byte addressed
`ifndef SERIAL_PORT_STATUS_DEFS_SVH
`define SERIAL_PORT_STATUS_DEFS_SVH

`define SPS_STATUS_OFS   8'h00
`define SPS_CTRL_OFS     8'h04

`define SPS_SMP_BIT      7
`define SPS_CKE_BIT      6
`define SPS_DA_BIT       5
`define SPS_STOP_BIT     4
`define SPS_START_BIT    3
`define SPS_RW_BIT       2
`define SPS_UA_BIT       1
`define SPS_BF_BIT       0

`define SPS_EN_BIT       0
`define SPS_MODE_BIT     1
`define SPS_ADDR_LSB     8
`define SPS_ADDR_MSB     14

`define SPS_STATUS_RST   8'h00
`define SPS_OWN_ADDR_RST 7'h00
`define SPS_BIT_LAST     4'h8

`endif

// >>> logic/serial_port_status_pkg.sv
// types shared by the status flag block and its bus watcher
// assumes nothing of its surroundings
package serial_port_status_pkg;

   typedef enum logic {
      MODE_SPI = 1'b0,
      MODE_I2C = 1'b1
   } port_mode_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ADDR = 2'b01,
      ST_DATA = 2'b10
   } watch_state_t;

   // each field toggles once per event on the link clock
   typedef struct packed {
      logic start;
      logic stop;
      logic byte_done;
      logic nack;
   } link_tg_t;

   // held stable from one byte toggle to the next
   typedef struct packed {
      logic [7:0] value;
      logic       is_addr;
   } link_byte_t;

endpackage

// >>> logic/bus_watch.sv
// i2c bus watcher on the free-running link sampling clock
// assumes scl and sda arrive asynchronous; reports by toggles
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_status_defs.svh"

module bus_watch
   import serial_port_status_pkg::*;
(
   // link clock and reset request from the system domain
   input  wire logic       lclk_i,
   input  wire logic       rst_i,
   // bus pins
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   // events toward the system domain
   output link_tg_t        tg_o,
   output link_byte_t      byte_o
);

   logic [1:0]   rst_s;
   logic [1:0]   scl_s;
   logic [1:0]   sda_s;
   logic         scl_d;
   logic         sda_d;
   logic         lrst;
   watch_state_t state_r;
   logic [3:0]   cnt_r;
   logic [7:0]   shift_r;
   link_tg_t     tg_r;
   link_byte_t   byte_r;

   assign lrst = rst_s[1];

   // reset is brought into the link domain before use
   always_ff @(posedge lclk_i) begin
      rst_s <= {rst_s[0], rst_i};
   end

   always_ff @(posedge lclk_i) begin
      if (lrst) begin
         scl_s <= 2'h3;
         sda_s <= 2'h3;
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_s <= {scl_s[0], scl_i};
         sda_s <= {sda_s[0], sda_i};
         scl_d <= scl_s[1];
         sda_d <= sda_s[1];
      end
   end

   wire start_det = scl_s[1] && scl_d && sda_d && !sda_s[1];
   wire stop_det  = scl_s[1] && scl_d && !sda_d && sda_s[1];
   wire scl_rise  = scl_s[1] && !scl_d;
   wire in_byte   = (state_r != ST_IDLE);
   wire ack_slot  = (cnt_r == `SPS_BIT_LAST);

   always_ff @(posedge lclk_i) begin
      if (lrst) begin
         state_r <= ST_IDLE;
         cnt_r   <= 4'h0;
         shift_r <= 8'h00;
         tg_r    <= '0;
         byte_r  <= '0;
      end else if (start_det) begin
         state_r  <= ST_ADDR;
         cnt_r    <= 4'h0;
         tg_r.start <= ~tg_r.start;
      end else if (stop_det) begin
         state_r <= ST_IDLE;
         tg_r.stop <= ~tg_r.stop;
      end else if (scl_rise && in_byte && ack_slot) begin
         cnt_r   <= 4'h0;
         state_r <= ST_DATA;
         if (sda_s[1]) begin
            tg_r.nack <= ~tg_r.nack;
         end
      end else if (scl_rise && in_byte) begin
         cnt_r   <= cnt_r + 4'h1;
         shift_r <= {shift_r[6:0], sda_s[1]};
         if (cnt_r == 4'h7) begin
            byte_r.value   <= {shift_r[6:0], sda_s[1]};
            byte_r.is_addr <= (state_r == ST_ADDR);
            tg_r.byte_done <= ~tg_r.byte_done;
         end
      end
   end

   assign tg_o   = tg_r;
   assign byte_o = byte_r;

endmodule

`default_nettype wire

// >>> dv/i2c_peer.sv
// bus peer that acts as i2c master and as acknowledger of each byte unless nak is set
// assumes pull-ups on both lines: a released line reads high
`timescale 1ns/1ps
`default_nettype none

module i2c_peer (
   // link clock
   input  wire logic lclk_i,
   // bus lines
   output logic      scl_o,
   output logic      sda_o
);
   // set by the bench to answer the following bytes with a nack
   logic nak = 1'b0;

   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end

   // each phase lasts 4 link cycles, so the watcher sees every level
   task automatic step(input logic c, input logic d);
      repeat (4) @(posedge lclk_i);
      {scl_o, sda_o} <= {c, d};
   endtask

   // scl drops first, so a repeated start never looks like a stop
   task automatic start();
      step(1'b0, 1'b1);
      step(1'b1, 1'b1);
      step(1'b1, 1'b0);
      step(1'b0, 1'b0);
   endtask

   task automatic stop();
      step(1'b0, 1'b0);
      step(1'b1, 1'b0);
      step(1'b1, 1'b1);
   endtask

   // msb first, then the ack slot, pulled low unless nak is set
   task automatic send(input logic [7:0] b);
      logic [8:0] f;
      f = {b, nak};
      for (int i = 8; i >= 0; i--) begin
         step(1'b0, f[i]);
         step(1'b1, f[i]);
      end
      step(1'b0, 1'b0);
   endtask
endmodule
`default_nettype wire

// >>> dv/tb_top.sv
// self-checking bench of the serial port status flag block
// assumes the design files and the i2c peer model are compiled first
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   typedef struct packed {
      logic [31:0] ctrl;
      logic [7:0]  stat;
      logic        tx;
      logic        smb;
      logic        en;
   } row_t;

   logic             clk_i  = 1'b0;
   logic             rst_i  = 1'b1;
   logic             lclk_i = 1'b0;
   logic             cyc_i  = 1'b0;
   logic             stb_i  = 1'b0;
   logic             we_i   = 1'b0;
   logic [7:0]       adr_i  = 8'h00;
   logic [3:0]       sel_i  = 4'h0;
   logic [31:0]      dat_i  = 32'h0;
   logic [31:0]      q;
   wire logic [31:0] dat_o;
   wire logic        ack_o;
   wire logic        tx_o;
   wire logic        smb_o;
   wire logic        en_o;
   wire logic        scl;
   wire logic        sda;
   int               errors    = 0;
   int               tests_run = 0;
   int               cycles    = 0;
   row_t             rows [5]  = '{
      '{32'h1, 8'h40, 1'b1, 1'b0, 1'b1},
      '{32'h1, 8'h80, 1'b0, 1'b0, 1'b1},
      '{32'h2, 8'h40, 1'b0, 1'b0, 1'b0},
      '{32'h3, 8'hC0, 1'b0, 1'b1, 1'b1},
      '{32'h3, 8'h00, 1'b0, 1'b0, 1'b1}};

   always #50 clk_i = ~clk_i;

   // odd offset keeps the link clock out of phase with the system clock
   initial begin
      #13;
      forever #32 lclk_i = ~lclk_i;
   end

   serial_port_status dut (
      .clk_i(clk_i), .rst_i(rst_i), .lclk_i(lclk_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
      .ack_o(ack_o), .scl_i(scl), .sda_i(sda), .tx_on_idle_edge_o(tx_o),
      .smbus_thresh_o(smb_o), .port_enable_o(en_o));

   i2c_peer peer (.lclk_i(lclk_i), .scl_o(scl), .sda_o(sda));

   task automatic summarize();
      $display("compares %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask

   // classic single cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, d, 4'hF};
      @(posedge clk_i);
      while (ack_o !== 1'b1) @(posedge clk_i);
      q = dat_o;
      {cyc_i, stb_i} <= 2'b00;
   endtask

   // flags cross from the link side, so let them settle first
   task automatic flags(input string n, input logic [7:0] e, input logic [7:0] m);
      repeat (20) @(posedge clk_i);
      wb(1'b0, 8'h00, 32'h0);
      chk(n, {24'h0, e}, q & {24'h0, m});
      $display("test %s done", n);
   endtask

   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         errors++;
         summarize();
      end
   end

   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      flags("status_rst", 8'h00, 8'hFF);
      wb(1'b0, 8'h04, 32'h0);
      chk("ctrl_rst", 32'h0, q);
      foreach (rows[i]) begin
         wb(1'b1, 8'h04, rows[i].ctrl);
         wb(1'b1, 8'h00, {24'h0, rows[i].stat});
         repeat (3) @(posedge clk_i);
         chk("tx_edge", {31'h0, rows[i].tx}, {31'h0, tx_o});
         chk("smbus", {31'h0, rows[i].smb}, {31'h0, smb_o});
         chk("enable", {31'h0, rows[i].en}, {31'h0, en_o});
         wb(1'b0, 8'h00, 32'h0);
         chk("status", {24'h0, rows[i].stat}, q);
      end
      $display("test steering rows done");
      wb(1'b1, 8'h00, 32'hFF);
      flags("ro_bits", 8'hC0, 8'hFF);
      wb(1'b1, 8'h10, 32'h1);
      wb(1'b0, 8'h10, 32'h0);
      chk("unmapped", 32'h0, q);
      wb(1'b1, 8'h04, 32'h2A03);
      wb(1'b1, 8'h00, 32'h0);
      peer.start();
      flags("start", 8'h08, 8'hFB);
      peer.send(8'h55);
      flags("addr_read", 8'h0C, 8'hFF);
      peer.send(8'hA5);
      flags("data", 8'h2C, 8'hFF);
      peer.stop();
      flags("stop", 8'h30, 8'hFB);
      peer.start();
      flags("restart", 8'h28, 8'hFB);
      wb(1'b1, 8'h04, 32'h2A02);
      flags("disable", 8'h20, 8'hFB);
      peer.stop();
      flags("ignored", 8'h20, 8'hFB);
      wb(1'b1, 8'h04, 32'h2A03);
      peer.start();
      peer.send(8'h54);
      flags("addr_write", 8'h08, 8'hFF);
      peer.nak = 1'b1;
      peer.send(8'h00);
      peer.nak = 1'b0;
      flags("nack", 8'h28, 8'hFB);
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      flags("reset_again", 8'h00, 8'hFF);
      summarize();
   end
endmodule
`default_nettype wire
